// [dual_timer.sv]
// control, mode and count logic of two timer/counters
// Summary of operation
// - timer 1 rollover sets flag, vector clears
// - timer 0 rollover sets flag, vector clears
// - run bit one starts timer 1
// - run bit one starts timer 0
// - pin 0 interrupt sets flag, edge acknowledged
// - gate bit requires pin high to count
// - select counts prescaled clock or pin falls
// - mode 1 cascades bytes into sixteen bits
// - timer 1 mode 2 counts low byte
// - timer 1 reload low from high byte
// - timer 0 reload low from high byte
// - timer 0 mode 3 splits bytes
// - mode 0 five-bit prescaler feeds high byte
// - timer 1 mode 3 holds count
`include "timer_consts.svh"
module dual_timer
  import timer_pkg::*;
#(
  parameter int PRESCALE = `PRESCALE_DIV
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // register port
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_rd_i,
  output logic [7:0] sfr_rdata_o,
  // pins
  input wire logic t0_count_pin_i,
  input wire logic t1_count_pin_i,
  input wire logic ext_pin_a_n_i,
  input wire logic ext_pin_b_n_i,
  // interrupt vector acknowledges
  input wire logic t0_vector_i,
  input wire logic t1_vector_i,
  input wire logic ext0_vector_i,
  input wire logic ext1_vector_i,
  // interrupt requests
  output logic t0_overflow_flag_o,
  output logic t1_overflow_flag_o,
  output logic ext_ext_pin_b_flag_o,
  output logic ext_ext_pin_a_flag_o
);
  // refuse a divider that the 8-bit counter cannot serve
  if (PRESCALE < 1 || PRESCALE > 256) begin : g_bad_prescale
    $error("PRESCALE must be 1 to 256");
  end

  localparam logic [7:0] PRESC_LAST = 8'(PRESCALE - 1);

  // ==========================================================
  // helpers
  function automatic logic [8:0] inc8(input logic [7:0] x);
    inc8 = {1'b0, x} + 9'h001;
  endfunction : inc8

  // one count step, result is {overflow, high, low}
  function automatic logic [16:0] step_pair(input timer_mode_t m, input logic [7:0] lo,
                                            input logic [7:0] hi);
    logic [8:0] l;
    logic [8:0] h;
    logic [5:0] p;
    l = inc8(lo);
    h = inc8(hi);
    p = {1'b0, lo[4:0]} + 6'h01;
    unique case (m)
      MODE_13BIT: step_pair = p[5] ? {h[8], h[7:0], lo[7:5], p[4:0]}
                                   : {1'b0, hi, lo[7:5], p[4:0]};
      MODE_16BIT: step_pair = l[8] ? {h[8], h[7:0], 8'h00} : {1'b0, hi, l[7:0]};
      MODE_RELOAD: step_pair = l[8] ? {1'b1, hi, hi} : {1'b0, hi, l[7:0]};
      MODE_SPLIT: step_pair = {l[8], hi, l[7:0]};
    endcase
  endfunction : step_pair

  // ==========================================================
  // registers
  logic [7:0] mode_reg;
  logic t0_run_bit, t1_run_bit, ext_ext_pin_b_type, ext_ext_pin_a_type;
  logic [7:0] t0_count_low, t0_count_high, t1_count_low, t1_count_high;
  timer_mode_t t0_mode, t1_mode;
  logic wr_ctrl, wr_mode, wr_tl0, wr_th0, wr_tl1, wr_th1;

  assign wr_ctrl = sfr_wr_i && sfr_addr_i == `ADDR_RUN_FLAG_CTRL;
  assign wr_mode = sfr_wr_i && sfr_addr_i == `ADDR_MODE_SELECT;
  assign wr_tl0 = sfr_wr_i && sfr_addr_i == `ADDR_T0_COUNT_LOW;
  assign wr_th0 = sfr_wr_i && sfr_addr_i == `ADDR_T0_COUNT_HIGH;
  assign wr_tl1 = sfr_wr_i && sfr_addr_i == `ADDR_T1_COUNT_LOW;
  assign wr_th1 = sfr_wr_i && sfr_addr_i == `ADDR_T1_COUNT_HIGH;

  assign t0_mode = timer_mode_t'({mode_reg[`BIT_T0_MODE_HI], mode_reg[`BIT_T0_MODE_LO]});
  assign t1_mode = timer_mode_t'({mode_reg[`BIT_T1_MODE_HI], mode_reg[`BIT_T1_MODE_LO]});

  // run, type and mode bits; software should stop a timer before a mode change
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      mode_reg <= `RESET_BYTE;
      t0_run_bit <= 1'b0;
      t1_run_bit <= 1'b0;
      ext_ext_pin_b_type <= 1'b0;
      ext_ext_pin_a_type <= 1'b0;
    end else if (ce_i) begin
      if (wr_mode) begin
        mode_reg <= sfr_wdata_i;
      end
      if (wr_ctrl) begin
        t0_run_bit <= sfr_wdata_i[`BIT_T0_RUN];
        t1_run_bit <= sfr_wdata_i[`BIT_T1_RUN];
        ext_ext_pin_b_type <= sfr_wdata_i[`BIT_EXT0_TYPE];
        ext_ext_pin_a_type <= sfr_wdata_i[`BIT_EXT1_TYPE];
      end
    end
  end

  // ==========================================================
  // count sources
  logic [7:0] presc;
  logic presc_tick, t0_pin_q, t1_pin_q, t0_src, t1_src, t0_split;
  logic t0_lo_inc, t0_hi_inc, t1_inc;
  logic [16:0] t0_next, t1_next;
  logic [8:0] th0_split_next;
  logic t0_ovf, t0_hi_ovf, t1_ovf;

  // system clock divider shared by both timers
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      presc <= 8'h00;
    end else if (ce_i) begin
      presc <= presc_tick ? 8'h00 : presc + 8'h01;
    end
  end

  assign presc_tick = presc == PRESC_LAST;

  // count pins idle high so the first sample after reset is no edge
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      t0_pin_q <= 1'b1;
      t1_pin_q <= 1'b1;
    end else if (ce_i) begin
      t0_pin_q <= t0_count_pin_i;
      t1_pin_q <= t1_count_pin_i;
    end
  end

  assign t0_src = mode_reg[`BIT_T0_CSEL] ? (t0_pin_q & ~t0_count_pin_i) : presc_tick;
  assign t1_src = mode_reg[`BIT_T1_CSEL] ? (t1_pin_q & ~t1_count_pin_i) : presc_tick;
  assign t0_split = t0_mode == MODE_SPLIT;

  // gating: pin must be high while the gate bit is set
  assign t0_lo_inc = t0_src & t0_run_bit
                     & (~mode_reg[`BIT_T0_GATE] | ext_pin_b_n_i);
  // split high byte borrows the timer-1 run bit and always counts the clock
  assign t0_hi_inc = t0_split & t1_run_bit & presc_tick;
  // timer 1 loses its run bit to a split timer 0; mode 3 is its only stop then
  assign t1_inc = t1_src & (t1_mode != MODE_SPLIT)
                  & (t0_split | (t1_run_bit & (~mode_reg[`BIT_T1_GATE] | ext_pin_a_n_i)));

  assign t0_next = step_pair(t0_mode, t0_count_low, t0_count_high);
  assign t1_next = step_pair(t1_mode, t1_count_low, t1_count_high);
  assign th0_split_next = inc8(t0_count_high);
  assign t0_ovf = t0_lo_inc & t0_next[16];
  assign t0_hi_ovf = t0_hi_inc & th0_split_next[8];
  assign t1_ovf = t1_inc & t1_next[16];

  // ==========================================================
  // count bytes; a software write wins over a count in the same cycle
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      t0_count_low <= `RESET_BYTE;
      t0_count_high <= `RESET_BYTE;
    end else if (ce_i) begin
      if (wr_tl0) begin
        t0_count_low <= sfr_wdata_i;
      end else if (t0_lo_inc) begin
        t0_count_low <= t0_next[7:0];
      end
      if (wr_th0) begin
        t0_count_high <= sfr_wdata_i;
      end else if (t0_hi_inc) begin
        t0_count_high <= th0_split_next[7:0];
      end else if (t0_lo_inc && !t0_split) begin
        t0_count_high <= t0_next[15:8];
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      t1_count_low <= `RESET_BYTE;
      t1_count_high <= `RESET_BYTE;
    end else if (ce_i) begin
      if (wr_tl1) begin
        t1_count_low <= sfr_wdata_i;
      end else if (t1_inc) begin
        t1_count_low <= t1_next[7:0];
      end
      if (wr_th1) begin
        t1_count_high <= sfr_wdata_i;
      end else if (t1_inc) begin
        t1_count_high <= t1_next[15:8];
      end
    end
  end

  // ==========================================================
  // overflow flags; set beats both the vector clear and a write
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      t0_overflow_flag_o <= 1'b0;
    end else if (ce_i) begin
      if (t0_ovf) begin
        t0_overflow_flag_o <= 1'b1;
      end else if (wr_ctrl) begin
        t0_overflow_flag_o <= sfr_wdata_i[`BIT_T0_OVF];
      end else if (t0_vector_i) begin
        t0_overflow_flag_o <= 1'b0;
      end
    end
  end

  // in split mode the flag belongs to the timer-0 high byte
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      t1_overflow_flag_o <= 1'b0;
    end else if (ce_i) begin
      if (t0_split ? t0_hi_ovf : t1_ovf) begin
        t1_overflow_flag_o <= 1'b1;
      end else if (wr_ctrl) begin
        t1_overflow_flag_o <= sfr_wdata_i[`BIT_T1_OVF];
      end else if (t1_vector_i) begin
        t1_overflow_flag_o <= 1'b0;
      end
    end
  end

  // ==========================================================
  // external interrupt flags
  ext_int_detect u_ext0 (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .pin_n_i(ext_pin_b_n_i),
    .edge_mode_i(ext_ext_pin_b_type),
    .ack_i(ext0_vector_i),
    .wr_i(wr_ctrl),
    .wr_val_i(sfr_wdata_i[`BIT_EXT0_FLAG]),
    .flag_o(ext_ext_pin_b_flag_o)
  );

  ext_int_detect u_ext1 (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .pin_n_i(ext_pin_a_n_i),
    .edge_mode_i(ext_ext_pin_a_type),
    .ack_i(ext1_vector_i),
    .wr_i(wr_ctrl),
    .wr_val_i(sfr_wdata_i[`BIT_EXT1_FLAG]),
    .flag_o(ext_ext_pin_a_flag_o)
  );

  // ==========================================================
  // read data, registered; unmapped addresses read zero
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sfr_rdata_o <= `UNMAPPED_READ;
    end else if (ce_i && sfr_rd_i) begin
      unique case (sfr_addr_i)
        `ADDR_RUN_FLAG_CTRL: sfr_rdata_o <= {t1_overflow_flag_o, t1_run_bit,
                                             t0_overflow_flag_o, t0_run_bit,
                                             ext_ext_pin_a_flag_o, ext_ext_pin_a_type,
                                             ext_ext_pin_b_flag_o, ext_ext_pin_b_type};
        `ADDR_MODE_SELECT: sfr_rdata_o <= mode_reg;
        `ADDR_T0_COUNT_LOW: sfr_rdata_o <= t0_count_low;
        `ADDR_T0_COUNT_HIGH: sfr_rdata_o <= t0_count_high;
        `ADDR_T1_COUNT_LOW: sfr_rdata_o <= t1_count_low;
        `ADDR_T1_COUNT_HIGH: sfr_rdata_o <= t1_count_high;
        default: sfr_rdata_o <= `UNMAPPED_READ;
      endcase
    end
  end

  // ==========================================================
  // checks
  logic wr_any;
  assign wr_any = sfr_wr_i;

  sequence t0_wraps;
    ce_i && t0_lo_inc && t0_count_low == 8'hFF && !wr_any;
  endsequence

  a_t0_ovf_sets: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (ce_i && t0_ovf) |=> t0_overflow_flag_o)
    else $error("timer 0 overflow flag not set");

  a_t0_vec_clears: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (ce_i && t0_vector_i && !t0_ovf && !wr_ctrl) |=> !t0_overflow_flag_o)
    else $error("timer 0 flag not cleared by vector");

  a_t1_ovf_sets: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (ce_i && t1_ovf && !t0_split) |=> t1_overflow_flag_o)
    else $error("timer 1 overflow flag not set");

  a_t0_stopped_holds: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (ce_i && !t0_run_bit && !wr_any) |=> $stable(t0_count_low))
    else $error("stopped timer 0 changed");

  a_gate_blocks: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (ce_i && mode_reg[`BIT_T0_GATE] && !ext_pin_b_n_i && !wr_any) |=> $stable(t0_count_low))
    else $error("gated timer 0 counted with pin low");

  a_t0_reload: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (t0_wraps and t0_mode == MODE_RELOAD) |=>
      t0_count_low == $past(t0_count_high) && $stable(t0_count_high))
    else $error("timer 0 reload wrong");

  a_t1_reload: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (ce_i && t1_inc && t1_mode == MODE_RELOAD && t1_count_low == 8'hFF && !wr_any) |=>
      t1_count_low == $past(t1_count_high) && t1_overflow_flag_o == !t0_split ||
      t0_split)
    else $error("timer 1 reload wrong");

  a_t0_cascade: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (t0_wraps and t0_mode == MODE_16BIT) |=>
      t0_count_low == 8'h00 && t0_count_high == $past(t0_count_high) + 8'h01)
    else $error("timer 0 sixteen-bit carry wrong");

  a_t0_prescale: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (ce_i && t0_lo_inc && t0_mode == MODE_13BIT && t0_count_low[4:0] == 5'h1F && !wr_any)
      |=> t0_count_low[4:0] == 5'h00 && t0_count_high == $past(t0_count_high) + 8'h01)
    else $error("thirteen-bit prescaler carry wrong");

  a_t1_halt: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (ce_i && t1_mode == MODE_SPLIT && !wr_any) |=>
      $stable(t1_count_low) && $stable(t1_count_high))
    else $error("timer 1 counted in halt mode");

  a_split_high: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (ce_i && t0_split && t1_run_bit && presc_tick && t0_count_high == 8'hFF && !wr_any)
      |=> t1_overflow_flag_o && t0_count_high == 8'h00)
    else $error("split high byte overflow wrong");
endmodule : dual_timer

// [timer_consts.svh]
// constants for the dual timer control block
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH
// ==========================================================
// register addresses
`define ADDR_RUN_FLAG_CTRL 8'h88
`define ADDR_MODE_SELECT 8'h89
`define ADDR_T0_COUNT_LOW 8'h8A
`define ADDR_T1_COUNT_LOW 8'h8B
`define ADDR_T0_COUNT_HIGH 8'h8C
`define ADDR_T1_COUNT_HIGH 8'h8D
// ==========================================================
// run/flag control bit positions
`define BIT_T1_OVF 7
`define BIT_T1_RUN 6
`define BIT_T0_OVF 5
`define BIT_T0_RUN 4
`define BIT_EXT1_FLAG 3
`define BIT_EXT1_TYPE 2
`define BIT_EXT0_FLAG 1
`define BIT_EXT0_TYPE 0
// ==========================================================
// mode select field positions
`define BIT_T1_GATE 7
`define BIT_T1_CSEL 6
`define BIT_T1_MODE_HI 5
`define BIT_T1_MODE_LO 4
`define BIT_T0_GATE 3
`define BIT_T0_CSEL 2
`define BIT_T0_MODE_HI 1
`define BIT_T0_MODE_LO 0
// ==========================================================
// reset values and timing
`define RESET_BYTE 8'h00
`define UNMAPPED_READ 8'h00
`define PRESCALE_DIV 6
`endif

// [timer_pkg.sv]
// types shared by the dual timer control block
package timer_pkg;
  // ==========================================================
  // operating modes, in mode-code order
  typedef enum logic [1:0] {
    MODE_13BIT,
    MODE_16BIT,
    MODE_RELOAD,
    MODE_SPLIT
  } timer_mode_t;
endpackage : timer_pkg

// [ext_int_detect.sv]
// external interrupt flag for one active-low pin
`include "timer_consts.svh"
module ext_int_detect
  import timer_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // pin and control
  input wire logic pin_n_i,
  input wire logic edge_mode_i,
  input wire logic ack_i,
  input wire logic wr_i,
  input wire logic wr_val_i,
  // flag
  output logic flag_o
);
  // ==========================================================
  // edge detection
  logic pin_q;
  logic fall;

  // previous pin level, idle high
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pin_q <= 1'b1;
    end else if (ce_i) begin
      pin_q <= pin_n_i;
    end
  end

  assign fall = pin_q & ~pin_n_i;

  // level mode tracks the pin; edge mode latches, set beats clear
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      flag_o <= 1'b0;
    end else if (ce_i) begin
      if (!edge_mode_i) begin
        flag_o <= ~pin_n_i;
      end else if (fall) begin
        flag_o <= 1'b1;
      end else if (wr_i) begin
        flag_o <= wr_val_i;
      end else if (ack_i) begin
        flag_o <= 1'b0;
      end
    end
  end

  // ==========================================================
  // checks
  sequence pin_falls;
    (ce_i && pin_n_i) ##1 (ce_i && !pin_n_i && edge_mode_i);
  endsequence

  a_edge_sets_flag: assert property (
    @(posedge sys_clk_i) disable iff (rst_i) pin_falls |=> flag_o)
    else $error("edge on pin did not set flag");

  a_level_follows: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (ce_i && !edge_mode_i) |=> flag_o == !$past(pin_n_i))
    else $error("level flag does not follow pin");
endmodule : ext_int_detect

// [pin_model.sv]
// far side model: count pins, interrupt pins and the vectoring controller
module pin_model (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // bench controls and block flags, order {ext1, ext0, t1, t0}
  input wire logic [3:0] ack_en_i,
  input wire logic [3:0] flag_i,
  // pins {ext_pin_a, ext_pin_b, t1 count, t0 count} and vectors {ext1, ext0, t1, t0}
  output logic [3:0] pin_o,
  output logic [3:0] vector_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // all four pins rest high: count inputs idle and interrupt lines inactive
  initial begin
    pin_o = 4'hF;
  end
  // vector on alternate cycles while a flag and its enable stay high; each pulse lasts one cycle
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      vector_o <= 4'h0;
    end else begin
      vector_o <= flag_i & ack_en_i & ~vector_o;
    end
  end
  // pin level changes just after an edge
  task automatic set_pin(input int idx, input logic val);
    @(posedge sys_clk_i);
    pin_o[idx] <= val;
  endtask : set_pin
  // each level held two cycles so the block sees every fall
  task automatic count_falls(input int idx, input int n);
    for (int k = 0; k < n; k++) begin
      set_pin(idx, 1'b0);
      @(posedge sys_clk_i);
      set_pin(idx, 1'b1);
      @(posedge sys_clk_i);
    end
  endtask : count_falls
endmodule : pin_model

// [tb_dual_timer.sv]
// self-checking bench for the dual timer control block
`include "timer_consts.svh"
`define CHK(what, exp, got) begin n_checks++; if ((got) !== (exp)) begin n_fail++; \
  $display("mismatch %s expected %h seen %h", what, exp, got); end end
module tb_dual_timer
  import timer_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i, rst_i, sfr_wr_i, sfr_rd_i, ce;
  logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o;
  logic [3:0] pin, vec, flag, ack_en;
  int n_fail = 0;
  int n_checks = 0;
  int cycles = 0;
  // ==========================================================
  // clock, block and far side
  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  // short divider keeps timer-mode waits brief
  dual_timer #(.PRESCALE(2)) dual_timer_i (.sys_clk_i, .rst_i, .ce_i(ce),
    .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i, .sfr_rd_i, .sfr_rdata_o,
    .t0_count_pin_i(pin[0]), .t1_count_pin_i(pin[1]),
    .ext_pin_a_n_i(pin[3]), .ext_pin_b_n_i(pin[2]),
    .t0_vector_i(vec[0]), .t1_vector_i(vec[1]), .ext0_vector_i(vec[2]),
    .ext1_vector_i(vec[3]), .t0_overflow_flag_o(flag[0]), .t1_overflow_flag_o(flag[1]),
    .ext_ext_pin_b_flag_o(flag[2]), .ext_ext_pin_a_flag_o(flag[3]));
  pin_model pin_model_i (.sys_clk_i, .rst_i, .ack_en_i(ack_en), .flag_i(flag),
    .pin_o(pin), .vector_o(vec));
  // ==========================================================
  // bus and check helpers
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    sfr_addr_i <= a;
    sfr_wdata_i <= d;
    sfr_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    sfr_wr_i <= 1'b0;
  endtask : wr
  // read data lands at the edge that takes the strobe
  task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk_i);
    sfr_addr_i <= a;
    sfr_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    sfr_rd_i <= 1'b0;
    #1;
    `CHK($sformatf("reg %h", a), e, sfr_rdata_o)
  endtask : chk_reg
  // bounded wait; a flag that never arrives shows as a mismatch
  task automatic wait_flag(input int idx, input logic v, input int lim);
    int k;
    k = 0;
    #1;
    while (flag[idx] !== v && k < lim) begin
      @(posedge sys_clk_i);
      #1;
      k++;
    end
    `CHK($sformatf("flag %0d", idx), v, flag[idx])
  endtask : wait_flag
  task automatic ack(input int idx, input logic v);
    @(posedge sys_clk_i);
    ack_en[idx] <= v;
  endtask : ack
  // ==========================================================
  // scenarios
  task automatic t_reset();
    for (int a = 8'h88; a <= 8'h8D; a++) begin
      chk_reg(8'(a), `RESET_BYTE);
    end
    chk_reg(8'h90, `UNMAPPED_READ);
    $display("test reset done");
  endtask : t_reset
  task automatic t_reload0();
    wr(8'h8C, 8'hF0);
    wr(8'h8A, 8'hFF);
    wr(8'h89, 8'h06);
    wr(8'h88, 8'h10);
    pin_model_i.count_falls(0, 1);
    wait_flag(0, 1'b1, 0);
    chk_reg(8'h8A, 8'hF0);
    chk_reg(8'h8C, 8'hF0);
    ack(0, 1'b1);
    wait_flag(0, 1'b0, 4);
    ack(0, 1'b0);
    wr(8'h88, 8'h00);
    pin_model_i.count_falls(0, 2);
    chk_reg(8'h8A, 8'hF0);
    $display("test reload0 done");
  endtask : t_reload0
  task automatic t_mode1();
    wr(8'h89, 8'h50);
    wr(8'h8B, 8'hFE);
    wr(8'h8D, 8'hFF);
    wr(8'h88, 8'h40);
    pin_model_i.count_falls(1, 1);
    wait_flag(1, 1'b0, 0);
    chk_reg(8'h8B, 8'hFF);
    pin_model_i.count_falls(1, 1);
    wait_flag(1, 1'b1, 0);
    chk_reg(8'h8B, 8'h00);
    chk_reg(8'h8D, 8'h00);
    ack(1, 1'b1);
    wait_flag(1, 1'b0, 4);
    ack(1, 1'b0);
    $display("test mode1 done");
  endtask : t_mode1
  task automatic t_mode2();
    wr(8'h88, 8'h00);
    wr(8'h89, 8'h60);
    wr(8'h8D, 8'h80);
    wr(8'h8B, 8'hFF);
    wr(8'h88, 8'h40);
    pin_model_i.count_falls(1, 1);
    wait_flag(1, 1'b1, 0);
    chk_reg(8'h8B, 8'h80);
    chk_reg(8'h8D, 8'h80);
    pin_model_i.count_falls(1, 3);
    chk_reg(8'h8B, 8'h83);
    $display("test mode2 done");
  endtask : t_mode2
  task automatic t_mode0();
    wr(8'h88, 8'h00);
    wr(8'h89, 8'h04);
    wr(8'h8A, 8'hFF);
    wr(8'h8C, 8'h00);
    wr(8'h88, 8'h10);
    pin_model_i.count_falls(0, 1);
    chk_reg(8'h8A, 8'hE0);
    chk_reg(8'h8C, 8'h01);
    wr(8'h8C, 8'hFF);
    wr(8'h8A, 8'h1F);
    pin_model_i.count_falls(0, 1);
    wait_flag(0, 1'b1, 0);
    chk_reg(8'h8C, 8'h00);
    $display("test mode0 done");
  endtask : t_mode0
  task automatic t_gate();
    wr(8'h88, 8'h00);
    wr(8'h89, 8'h0D);
    wr(8'h8A, 8'h00);
    pin_model_i.set_pin(2, 1'b0);
    wr(8'h88, 8'h10);
    pin_model_i.count_falls(0, 2);
    chk_reg(8'h8A, 8'h00);
    pin_model_i.set_pin(2, 1'b1);
    pin_model_i.count_falls(0, 2);
    chk_reg(8'h8A, 8'h02);
    $display("test gate done");
  endtask : t_gate
  // clock enable low freezes counting and pin history
  task automatic t_freeze();
    wr(8'h88, 8'h00);
    wr(8'h89, 8'h05);
    wr(8'h8A, 8'h00);
    wr(8'h88, 8'h10);
    @(posedge sys_clk_i);
    ce <= 1'b0;
    pin_model_i.count_falls(0, 2);
    @(posedge sys_clk_i);
    ce <= 1'b1;
    chk_reg(8'h8A, 8'h00);
    pin_model_i.count_falls(0, 1);
    chk_reg(8'h8A, 8'h01);
    $display("test freeze done");
  endtask : t_freeze
  task automatic t_split();
    wr(8'h88, 8'h00);
    wr(8'h89, 8'h77);
    wr(8'h8B, 8'h05);
    wr(8'h8C, 8'hFE);
    wr(8'h8A, 8'hFF);
    wr(8'h88, 8'h50);
    pin_model_i.count_falls(0, 1);
    wait_flag(0, 1'b1, 0);
    wait_flag(1, 1'b1, 20);
    pin_model_i.count_falls(1, 2);
    chk_reg(8'h8B, 8'h05);
    $display("test split done");
  endtask : t_split
  task automatic t_ext();
    wr(8'h88, 8'h05);
    pin_model_i.set_pin(2, 1'b0);
    wait_flag(2, 1'b1, 4);
    pin_model_i.set_pin(2, 1'b1);
    wait_flag(2, 1'b1, 0);
    ack(2, 1'b1);
    wait_flag(2, 1'b0, 4);
    ack(2, 1'b0);
    pin_model_i.set_pin(3, 1'b0);
    wait_flag(3, 1'b1, 4);
    pin_model_i.set_pin(3, 1'b1);
    wr(8'h88, 8'h05);
    wait_flag(3, 1'b0, 0);
    wr(8'h88, 8'h00);
    pin_model_i.set_pin(3, 1'b0);
    wait_flag(3, 1'b1, 4);
    pin_model_i.set_pin(3, 1'b1);
    wait_flag(3, 1'b0, 4);
    $display("test ext done");
  endtask : t_ext
  // ==========================================================
  // verdict and run control
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop
  // the whole run needs well under a thousand cycles
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      $display("mismatch timeout expected 0 seen 1");
      report_and_stop();
    end
  end
  initial begin
    rst_i = 1'b1;
    ce = 1'b1;
    sfr_wr_i = 1'b0;
    sfr_rd_i = 1'b0;
    sfr_addr_i = 8'h00;
    sfr_wdata_i = 8'h00;
    ack_en = 4'h0;
    repeat (10) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_reload0();
    t_mode1();
    t_mode2();
    t_mode0();
    t_gate();
    t_freeze();
    t_split();
    t_ext();
    report_and_stop();
  end
endmodule : tb_dual_timer
